// ### mcfg_pkg.sv
`default_nettype none

package mcfg_pkg;

  // Register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_STATUS1   = 8'h41;
  localparam logic [7:0] OFF_MASK1     = 8'h43;
  localparam logic [7:0] OFF_INTRUSION = 8'h46;
  localparam logic [7:0] OFF_VSEL_FAN  = 8'h47;
  localparam logic [7:0] OFF_SADDR     = 8'h48;
  localparam logic [7:0] OFF_VSEL_HI   = 8'h49;
  localparam logic [7:0] OFF_TEMP_CFG  = 8'h4b;

  // Field positions
  localparam int unsigned INTR_TRIG_BIT = 7;
  localparam int unsigned TEMP_STAT_BIT = 4;
  localparam int unsigned FAN1_LSB      = 4;
  localparam int unsigned FAN2_LSB      = 6;
  localparam int unsigned SADDR_TOP_BIT = 7;

  // Reset values
  localparam logic [7:0] INTR_RST     = 8'h00;
  localparam logic [3:0] FAN_DIV_RST  = 4'h5;
  localparam logic [7:0] SADDR_RST    = 8'h2c;
  localparam logic [7:0] TEMP_CFG_RST = 8'h01;
  localparam logic [7:0] MASK1_RST    = 8'h00;
  // Upper bits of the voltage-id register: value is arbitrary
  localparam logic [6:0] IDENT_RST    = 7'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned INTR_PULSE_MS  = 20;
  localparam int unsigned PULSE_CNT_W    = 22;
  // Least time, so round up
  localparam int unsigned INTR_PULSE_CYC =
    (INTR_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Number of fan inputs
  localparam int unsigned NUM_FANS = 2;

  // Temperature interrupt modes
  typedef enum logic [1:0] {
    TMODE_DEFAULT_A = 2'h0,
    TMODE_ONE_TIME  = 2'h1,
    TMODE_COMPARE   = 2'h2,
    TMODE_DEFAULT_B = 2'h3
  } mcfg_tmode_t;

  // Intrusion pulse states, one-hot
  typedef enum logic [1:0] {
    PST_IDLE = 2'h1,
    PST_LOW  = 2'h2
  } mcfg_pstate_t;

endpackage

`default_nettype wire

// ### mcfg_pulse_gen.sv
`default_nettype none

module mcfg_pulse_gen
  import mcfg_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic                   ce,
  input  wire logic                   start,
  input  wire logic [PULSE_CNT_W-1:0] pulse_cycles,
  output logic                        active,
  output logic                        done
);

  mcfg_pstate_t           state_reg;
  mcfg_pstate_t           state_next;
  logic [PULSE_CNT_W-1:0] cnt_reg;
  logic [PULSE_CNT_W-1:0] cnt_next;

  // Start is ignored while a pulse runs, so a pulse is never cut short
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    done       = 1'b0;
    case (state_reg)
      PST_IDLE:
      begin
        if (start)
        begin
          state_next = PST_LOW;
          cnt_next   = pulse_cycles;
        end
      end
      PST_LOW:
      begin
        if (cnt_reg <= 22'h000001)
        begin
          state_next = PST_IDLE;
          done       = ce;
        end
        else
        begin
          cnt_next = cnt_reg - 22'h000001;
        end
      end
      default:
      begin
        state_next = PST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= PST_IDLE;
      cnt_reg   <= '0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign active = (state_reg == PST_LOW);

endmodule

`default_nettype wire

// ### mcfg_tach_prescale.sv
`default_nettype none

module mcfg_tach_prescale
  import mcfg_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       tach_in,
  input  wire logic       meas_start,
  input  wire logic [1:0] div_sel,
  output logic            tach_out
);

  logic       prev_reg;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] limit;
  logic       out_reg;
  logic       out_next;
  logic       edge_seen;

  // Divisor is latched only at a measurement start so a count is never mixed
  always_comb
  begin
    edge_seen = tach_in & ~prev_reg;
    sel_next  = meas_start ? div_sel : sel_reg;
    case (sel_reg)
      2'h0:    limit = 3'h0;
      2'h1:    limit = 3'h1;
      2'h2:    limit = 3'h3;
      default: limit = 3'h7;
    endcase
    cnt_next = meas_start ? 3'h0 : cnt_reg;
    out_next = 1'b0;
    if (edge_seen && !meas_start)
    begin
      if (cnt_reg >= limit)
      begin
        cnt_next = 3'h0;
        out_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_reg <= 1'b0;
      sel_reg  <= FAN_DIV_RST[1:0];
      cnt_reg  <= 3'h0;
      out_reg  <= 1'b0;
    end
    else if (ce)
    begin
      prev_reg <= tach_in;
      sel_reg  <= sel_next;
      cnt_reg  <= cnt_next;
      out_reg  <= out_next;
    end
  end

  assign tach_out = out_reg;

  property p_div_count;
    @(posedge clock) disable iff (!resetn)
    (ce && edge_seen && !meas_start && cnt_reg < limit) |=> !tach_out;
  endproperty
  a_div_count: assert property (p_div_count)
    else $error("Prescaler emitted a pulse before its divisor count");

endmodule

`default_nettype wire

// ### mcfg_top.sv
`default_nettype none

module mcfg_top
  import mcfg_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = INTR_PULSE_CYC
)
(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic [4:0]        core_voltage_select_inputs,
  input  wire logic              addr_select_pin_low,
  input  wire logic              addr_select_pin_high,
  input  wire logic              conv_done,
  input  wire logic              temp_above_hot,
  input  wire logic              temp_below_hyst,
  input  wire logic [1:0]        tach_in,
  input  wire logic              meas_start,
  output logic [1:0]             tach_div_out,
  output logic                   chassis_pin_out,
  output logic                   chassis_pin_oe,
  output logic                   int_n
);

  // Register state
  logic [7:0]  intr_reg;
  logic [7:0]  intr_next;
  logic [3:0]  fan_div_reg;
  logic [3:0]  fan_div_next;
  logic [7:0]  saddr_reg;
  logic [7:0]  saddr_next;
  logic        strap_done_reg;
  logic        strap_done_next;
  logic [6:0]  ident_reg;
  logic [6:0]  ident_next;
  logic [7:0]  tcfg_reg;
  logic [7:0]  tcfg_next;
  logic [7:0]  mask1_reg;
  logic [7:0]  mask1_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  // Temperature state
  logic        flag_reg;
  logic        flag_next;
  logic        hot_active_reg;
  logic        hot_active_next;
  logic        comp_reg;
  logic        comp_next;
  logic        int_n_reg;
  logic        int_n_next;

  // Decodes and events
  logic        wr_intr;
  logic        wr_vsel_fan;
  logic        wr_saddr;
  logic        wr_vsel_hi;
  logic        wr_tcfg;
  logic        wr_mask1;
  logic        rd_status1;
  logic        pulse_start;
  logic        pulse_done;
  logic        pulse_active;
  logic        temp_set;
  logic        temp_stat;
  mcfg_tmode_t tmode;
  logic [7:0]  read_mux;

  logic [PULSE_CNT_W-1:0] pulse_len;

  assign pulse_len = PULSE_CYCLES[PULSE_CNT_W-1:0];

  // Address decode of the register port
  always_comb
  begin
    wr_intr     = reg_wr && (reg_addr == OFF_INTRUSION);
    wr_vsel_fan = reg_wr && (reg_addr == OFF_VSEL_FAN);
    wr_saddr    = reg_wr && (reg_addr == OFF_SADDR);
    wr_vsel_hi  = reg_wr && (reg_addr == OFF_VSEL_HI);
    wr_tcfg     = reg_wr && (reg_addr == OFF_TEMP_CFG);
    wr_mask1    = reg_wr && (reg_addr == OFF_MASK1);
    rd_status1  = reg_rd && (reg_addr == OFF_STATUS1);
  end

  // A second trigger while the pulse runs is dropped rather than queued
  assign pulse_start = wr_intr && reg_wdata[INTR_TRIG_BIT]
                       && !intr_reg[INTR_TRIG_BIT];

  mcfg_pulse_gen u_pulse (
    .clock        (clock),
    .resetn       (resetn),
    .ce           (ce),
    .start        (pulse_start),
    .pulse_cycles (pulse_len),
    .active       (pulse_active),
    .done         (pulse_done)
  );

  // Pin is open drain: only ever pulled low
  assign chassis_pin_out = 1'b0;
  assign chassis_pin_oe  = pulse_active;

  // Configuration registers, next values
  always_comb
  begin
    intr_next       = intr_reg;
    fan_div_next    = fan_div_reg;
    saddr_next      = saddr_reg;
    strap_done_next = 1'b1;
    ident_next      = ident_reg;
    tcfg_next       = tcfg_reg;
    mask1_next      = mask1_reg;
    if (wr_intr)
    begin
      intr_next[6:0] = reg_wdata[6:0];
    end
    if (pulse_start)
    begin
      intr_next[INTR_TRIG_BIT] = 1'b1;
    end
    else if (pulse_done)
    begin
      intr_next[INTR_TRIG_BIT] = 1'b0;
    end
    if (wr_vsel_fan)
    begin
      fan_div_next = reg_wdata[7:4];
    end
    // Straps are caught on the first enabled edge after reset release
    if (!strap_done_reg)
    begin
      saddr_next[1:0] = {addr_select_pin_high, addr_select_pin_low};
    end
    if (wr_saddr)
    begin
      saddr_next[6:0] = reg_wdata[6:0];
    end
    if (wr_vsel_hi)
    begin
      ident_next = reg_wdata[7:1];
    end
    if (wr_tcfg)
    begin
      tcfg_next = reg_wdata;
    end
    if (wr_mask1)
    begin
      mask1_next = reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      intr_reg       <= INTR_RST;
      fan_div_reg    <= FAN_DIV_RST;
      saddr_reg      <= SADDR_RST;
      strap_done_reg <= 1'b0;
      ident_reg      <= IDENT_RST;
      tcfg_reg       <= TEMP_CFG_RST;
      mask1_reg      <= MASK1_RST;
    end
    else if (ce)
    begin
      intr_reg       <= intr_next;
      fan_div_reg    <= fan_div_next;
      saddr_reg      <= saddr_next;
      strap_done_reg <= strap_done_next;
      ident_reg      <= ident_next;
      tcfg_reg       <= tcfg_next;
      mask1_reg      <= mask1_next;
    end
  end

  // Fan prescalers, divisor fields taken per fan
  for (genvar f = 0; f < NUM_FANS; f++)
  begin : g_fan
    mcfg_tach_prescale u_pre (
      .clock      (clock),
      .resetn     (resetn),
      .ce         (ce),
      .tach_in    (tach_in[f]),
      .meas_start (meas_start),
      .div_sel    (fan_div_reg[2*f +: 2]),
      .tach_out   (tach_div_out[f])
    );
  end

  // Temperature interrupt; a set in the clearing cycle wins over the clear
  always_comb
  begin
    tmode           = mcfg_tmode_t'(tcfg_reg[1:0]);
    hot_active_next = hot_active_reg;
    comp_next       = comp_reg;
    temp_set        = 1'b0;
    if (conv_done)
    begin
      comp_next = temp_above_hot;
      if (temp_above_hot)
      begin
        hot_active_next = 1'b1;
      end
      else if (temp_below_hyst)
      begin
        hot_active_next = 1'b0;
      end
      case (tmode)
        TMODE_ONE_TIME:  temp_set = temp_above_hot && !hot_active_reg;
        TMODE_COMPARE:   temp_set = 1'b0;
        default:         temp_set = hot_active_next;
      endcase
    end
    flag_next  = temp_set || (flag_reg && !rd_status1);
    temp_stat  = (tmode == TMODE_COMPARE) ? comp_reg : flag_reg;
    int_n_next = !(temp_stat && !mask1_reg[TEMP_STAT_BIT]);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      flag_reg       <= 1'b0;
      hot_active_reg <= 1'b0;
      comp_reg       <= 1'b0;
      int_n_reg      <= 1'b1;
    end
    else if (ce)
    begin
      flag_reg       <= flag_next;
      hot_active_reg <= hot_active_next;
      comp_reg       <= comp_next;
      int_n_reg      <= int_n_next;
    end
  end

  assign int_n = int_n_reg;

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    read_mux = 8'h00;
    case (reg_addr)
      OFF_STATUS1:   read_mux[TEMP_STAT_BIT] = temp_stat;
      OFF_MASK1:     read_mux = mask1_reg;
      OFF_INTRUSION: read_mux = intr_reg;
      OFF_VSEL_FAN:  read_mux = {fan_div_reg, core_voltage_select_inputs[3:0]};
      OFF_SADDR:     read_mux = {1'b0, saddr_reg[6:0]};
      OFF_VSEL_HI:   read_mux = {ident_reg, core_voltage_select_inputs[4]};
      OFF_TEMP_CFG:  read_mux = tcfg_reg;
      default:       read_mux = 8'h00;
    endcase
    rdata_next  = reg_rd ? read_mux : rdata_reg;
    rvalid_next = reg_rd;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else if (ce)
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_pulse_start;
    ce && pulse_start |=> chassis_pin_oe && intr_reg[INTR_TRIG_BIT];
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("Intrusion trigger did not start the low pulse");

  property p_trig_clear;
    $fell(chassis_pin_oe) |-> !intr_reg[INTR_TRIG_BIT];
  endproperty
  a_trig_clear: assert property (p_trig_clear)
    else $error("Trigger bit still set after the pulse ended");

  property p_intr_low_bits;
    ce && wr_intr |=> intr_reg[6:0] == $past(reg_wdata[6:0]);
  endproperty
  a_intr_low_bits: assert property (p_intr_low_bits)
    else $error("Intrusion reserved bits did not store write data");

  property p_vsel_low;
    ce && reg_rd && reg_addr == OFF_VSEL_FAN
      |=> reg_rdata[3:0] == $past(core_voltage_select_inputs[3:0]);
  endproperty
  a_vsel_low: assert property (p_vsel_low)
    else $error("Voltage select bits 3..0 read wrong");

  property p_saddr_top;
    ce && reg_rd && reg_addr == OFF_SADDR |=> !reg_rdata[SADDR_TOP_BIT];
  endproperty
  a_saddr_top: assert property (p_saddr_top)
    else $error("Bus address bit 7 read nonzero");

  property p_vsel_hi;
    ce && reg_rd && reg_addr == OFF_VSEL_HI
      |=> reg_rdata[0] == $past(core_voltage_select_inputs[4]);
  endproperty
  a_vsel_hi: assert property (p_vsel_hi)
    else $error("Fifth voltage select bit read wrong");

  property p_default_set;
    ce && conv_done && temp_above_hot && tcfg_reg[0] == tcfg_reg[1] |=> flag_reg;
  endproperty
  a_default_set: assert property (p_default_set)
    else $error("Default mode did not flag an over-hot conversion");

  property p_one_time;
    ce && tmode == TMODE_ONE_TIME && conv_done && hot_active_reg && !rd_status1
      && !flag_reg |=> !flag_reg;
  endproperty
  a_one_time: assert property (p_one_time)
    else $error("One-time mode flagged again without rearming");

  property p_compare;
    ce && tmode == TMODE_COMPARE && conv_done && !temp_above_hot
      && !wr_tcfg ##1 ce |=> int_n;
  endproperty
  a_compare: assert property (p_compare)
    else $error("Comparator interrupt stayed active below hot limit");

  property p_read_clear;
    ce && rd_status1 && !temp_set |=> !flag_reg;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Status read did not clear the temperature flag");

  property p_status_bit;
    ce && rd_status1 |=> reg_rdata[TEMP_STAT_BIT] == $past(temp_stat);
  endproperty
  a_status_bit: assert property (p_status_bit)
    else $error("Status bit 4 does not match the temperature flag");

  property p_mask;
    ce && mask1_reg[TEMP_STAT_BIT] |=> int_n;
  endproperty
  a_mask: assert property (p_mask)
    else $error("Masked temperature status drove the interrupt");

  c_pulse: cover property ($fell(chassis_pin_oe));
  c_onetime: cover property (tmode == TMODE_ONE_TIME && $rose(flag_reg));
  c_compare: cover property (tmode == TMODE_COMPARE && $fell(int_n));
  c_read_clear: cover property (rd_status1 && flag_reg);

endmodule

`default_nettype wire

// ### mcfg_host_model.sv
`default_nettype none

// Management bus host as seen at the strobe port: one request at a time
module mcfg_host_model
  import mcfg_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic                   reg_wr,
  output logic [DATA_W-1:0]      reg_wdata,
  output logic                   reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe; data is scrambled after so stale data never looks valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // One-cycle read strobe, then a bounded wait for the answer
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    ok       = 1'b0;
    d        = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      if (reg_rvalid === 1'b1)
      begin
        d  = reg_rdata;
        ok = 1'b1;
        break;
      end
      @(negedge clock);
    end
  endtask
endmodule

`default_nettype wire

// ### monitor_misc_config_temp_irq_test.sv
`default_nettype none

module monitor_misc_config_temp_irq_test;
  import mcfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Short pulse keeps the run brief; expectations follow this value
  localparam int unsigned PULSE = 20;
  localparam logic [4:0] VSEL = 5'h1a;

  logic              clock;
  logic              resetn;
  logic              ce;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_rvalid;
  logic              conv_done;
  logic              temp_above_hot;
  logic              temp_below_hyst;
  logic [1:0]        tach_in;
  logic              meas_start;
  logic [1:0]        tach_div_out;
  logic              chassis_pin_out;
  logic              chassis_pin_oe;
  logic              int_n;
  int                fail_count;
  int                cmp_count;

  mcfg_top #(.PULSE_CYCLES(PULSE)) mcfg_top_inst (
    .clock(clock), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .core_voltage_select_inputs(VSEL),
    .addr_select_pin_low(1'b0), .addr_select_pin_high(1'b1),
    .conv_done(conv_done), .temp_above_hot(temp_above_hot),
    .temp_below_hyst(temp_below_hyst), .tach_in(tach_in), .meas_start(meas_start),
    .tach_div_out(tach_div_out), .chassis_pin_out(chassis_pin_out),
    .chassis_pin_oe(chassis_pin_oe), .int_n(int_n)
  );

  mcfg_host_model mcfg_host_model_inst (
    .clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  // Read and compare; a missing answer ends the run
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    mcfg_host_model_inst.read_reg(a, d, ok);
    if (!ok)
    begin
      $display("wrong value read answer expected 1 seen 0");
      fail_count++;
      finish_test();
    end
    check($sformatf("reg %h", a), d, exp);
  endtask

  // One completed conversion with the given comparator results
  task automatic conv(input logic hot, input logic hyst);
    @(negedge clock);
    conv_done       = 1'b1;
    temp_above_hot  = hot;
    temp_below_hyst = hyst;
    @(negedge clock);
    conv_done       = 1'b0;
  endtask

  task automatic test_reset_values();
    rd_check(8'h46, 8'h00);
    rd_check(8'h47, {4'h5, VSEL[3:0]});
    rd_check(8'h48, 8'h2e);
    rd_check(8'h49, {7'h00, VSEL[4]});
    rd_check(8'h4b, 8'h01);
    rd_check(8'h41, 8'h00);
    rd_check(8'h43, 8'h00);
    rd_check(8'h4a, 8'h00);
    $display("test reset values done");
  endtask

  // Read-only fields must ignore writes of all ones
  task automatic test_access();
    mcfg_host_model_inst.write_reg(8'h46, 8'h7f);
    rd_check(8'h46, 8'h7f);
    mcfg_host_model_inst.write_reg(8'h48, 8'hff);
    rd_check(8'h48, 8'h7f);
    mcfg_host_model_inst.write_reg(8'h47, 8'hff);
    rd_check(8'h47, {4'hf, VSEL[3:0]});
    mcfg_host_model_inst.write_reg(8'h49, 8'hff);
    rd_check(8'h49, {7'h7f, VSEL[4]});
    mcfg_host_model_inst.write_reg(8'h4a, 8'hff);
    rd_check(8'h4a, 8'h00);
    // A frozen block must ignore a write strobe
    ce = 1'b0;
    mcfg_host_model_inst.write_reg(8'h46, 8'h00);
    ce = 1'b1;
    rd_check(8'h46, 8'h7f);
    $display("test access done");
  endtask

  task automatic test_intrusion();
    int n;
    mcfg_host_model_inst.write_reg(8'h46, 8'h80);
    n = 0;
    rd_check(8'h46, 8'h80);
    n += 2;
    while (chassis_pin_oe === 1'b1 && n < 4 * PULSE)
    begin
      @(negedge clock);
      n++;
    end
    check("pulse length", n[7:0], PULSE[7:0]);
    check("pin level", {7'h00, chassis_pin_out}, 8'h00);
    rd_check(8'h46, 8'h00);
    $display("test intrusion done");
  endtask

  // Every divisor code on both fans, eight rising tach edges each
  task automatic test_prescale();
    int c0;
    int c1;
    for (int c = 0; c < 4; c++)
    begin
      mcfg_host_model_inst.write_reg(8'h47, {2'h3 - c[1:0], c[1:0], 4'h0});
      @(negedge clock);
      meas_start = 1'b1;
      @(negedge clock);
      meas_start = 1'b0;
      c0 = 0;
      c1 = 0;
      for (int i = 0; i < 20; i++)
      begin
        tach_in = (i < 16 && i % 2 == 0) ? 2'h3 : 2'h0;
        @(negedge clock);
        c0 += tach_div_out[0];
        c1 += tach_div_out[1];
      end
      check("fan1 pulses", c0[7:0], 8'd8 >> c);
      check("fan2 pulses", c1[7:0], 8'd8 >> (3 - c));
    end
    $display("test prescale done");
  endtask

  task automatic test_temp();
    // One-time mode from reset
    conv(1'b1, 1'b0);
    rd_check(8'h41, 8'h10);
    rd_check(8'h41, 8'h00);
    conv(1'b1, 1'b0);
    rd_check(8'h41, 8'h00);
    conv(1'b0, 1'b1);
    conv(1'b1, 1'b0);
    rd_check(8'h41, 8'h10);
    // Default modes; a conversion between the limits still re-flags
    for (int m = 0; m < 4; m += 3)
    begin
      mcfg_host_model_inst.write_reg(8'h4b, m[7:0]);
      conv(1'b0, 1'b1);
      rd_check(8'h41, 8'h00);
      conv(1'b1, 1'b0);
      rd_check(8'h41, 8'h10);
      conv(1'b0, 1'b0);
      rd_check(8'h41, 8'h10);
      conv(1'b0, 1'b1);
      rd_check(8'h41, 8'h00);
    end
    // Comparator mode: level follows the hot comparison
    mcfg_host_model_inst.write_reg(8'h4b, 8'h02);
    conv(1'b1, 1'b0);
    rd_check(8'h41, 8'h10);
    rd_check(8'h41, 8'h10);
    check("int_n active", {7'h00, int_n}, 8'h00);
    mcfg_host_model_inst.write_reg(8'h43, 8'h10);
    repeat (2) @(negedge clock);
    check("int_n masked", {7'h00, int_n}, 8'h01);
    mcfg_host_model_inst.write_reg(8'h43, 8'h00);
    repeat (2) @(negedge clock);
    check("int_n unmasked", {7'h00, int_n}, 8'h00);
    conv(1'b0, 1'b0);
    rd_check(8'h41, 8'h00);
    check("int_n idle", {7'h00, int_n}, 8'h01);
    $display("test temperature done");
  endtask

  initial
  begin
    fail_count      = 0;
    cmp_count       = 0;
    resetn          = 1'b0;
    ce              = 1'b1;
    conv_done       = 1'b0;
    temp_above_hot  = 1'b0;
    temp_below_hyst = 1'b0;
    tach_in         = 2'h0;
    meas_start      = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    test_reset_values();
    test_access();
    test_intrusion();
    test_prescale();
    test_temp();
    finish_test();
  end
endmodule

`default_nettype wire
